/* File: core/spc_core.sv */
// four-wire synchronous serial port, master or slave
// Summary of operation
// - four-line full-duplex character serial port: data in, data out, clock, select
// - both shifters share one clock: rate generator as master, pin as slave
// - one character shifts out while another shifts in, on opposite edges of the same clock
// - each direction has a holding register plus a shifter, depth two
// - most significant bit of the character goes out first
// - character length programmable from four to sixteen bits
// - buffered next character follows with no forced idle gap
// - master drives select and clock; slave takes both from outside
// - master clock at most a quarter, slave also at most a quarter of the system clock
// - master clock comes from its own programmable rate generator
// - rate source is system clock divided by 1, 4, 16 or 64
// - controller-in line is input as master, driven output as slave
// - controller-out line is driven output as master, input as slave
// - software sets clock phase and idle polarity
// - optional open-drain drive on serial outputs for multi-master sharing
// - loopback mode feeds transmit shifter output into receive shifter
// - select low while master sets fault, disables port, releases drivers
// - as slave, clock edges count only while select is asserted
// - master clock toggles only during character bits, else idle level
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module spc_core (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [spc_pkg::AW-1:0] reg_addr,
	input wire logic [spc_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [spc_pkg::DW-1:0] reg_rdata,
	input wire logic serial_shift_clock_in,
	output logic serial_shift_clock_out,
	output logic serial_shift_clock_oe_n,
	input wire logic controller_out_line_in,
	output logic controller_out_line_out,
	output logic controller_out_line_oe_n,
	input wire logic controller_in_line_in,
	output logic controller_in_line_out,
	output logic controller_in_line_oe_n,
	input wire logic select_input_n,
	output logic select_output_n
);
	typedef struct packed {
		logic [15:0] mode;
		logic fault;
		logic ovr;
		logic txf;
		logic [15:0] txd;
		logic rxf;
		logic [15:0] rxd;
		logic busy;
		logic [15:0] tsh;
		logic [15:0] rsh;
		logic [4:0] cnt;
		logic ph;
		logic dout;
		logic [5:0] pcnt;
		logic [4:0] bcnt;
		logic sprev;
		logic [15:0] rdata;
		logic sclk;
		logic sclk_oen;
		logic mosi;
		logic mosi_oen;
		logic miso;
		logic miso_oen;
		logic seln;
	} spc_core_st_t;

	spc_core_st_t r;
	spc_core_st_t n;
	logic [3:0] pin_q;
	logic sclk_q;
	logic sel_act;
	logic mosi_q;
	logic miso_q;
	logic rt;
	logic hedge;
	logic lead;
	logic trail;
	logic din;
	logic pop;
	logic done;
	logic [3:0] clen;
	logic [4:0] len;

	function automatic logic [5:0] pre_lim(input logic [1:0] sel);
		case (sel)
			2'h0: pre_lim = spc_pkg::PRE_LIM1;
			2'h1: pre_lim = spc_pkg::PRE_LIM4;
			2'h2: pre_lim = spc_pkg::PRE_LIM16;
			default: pre_lim = spc_pkg::PRE_LIM64;
		endcase
	endfunction : pre_lim

	// active-low enable; open drain only pulls low
	function automatic logic pin_oen(input logic drv, input logic od, input logic v);
		pin_oen = !(drv && (!od || !v));
	endfunction : pin_oen

	spc_sync3 #(
		.W(4)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d({serial_shift_clock_in, select_input_n, controller_out_line_in, controller_in_line_in}),
		.q(pin_q)
	);

	assign sclk_q = pin_q[3];
	assign sel_act = !pin_q[2];
	assign mosi_q = pin_q[1];
	assign miso_q = pin_q[0];
	assign clen = (r.mode[spc_pkg::M_CLEN+:4] < spc_pkg::CLEN_MIN) ?
		spc_pkg::CLEN_MIN : r.mode[spc_pkg::M_CLEN+:4];
	assign len = {1'b0, clen} + 5'h01;

	always_comb
	begin
		n = r;
		rt = 1'b0;
		hedge = 1'b0;
		lead = 1'b0;
		trail = 1'b0;
		done = 1'b0;
		pop = reg_rd && (reg_addr == spc_pkg::RXD_ADDR);
		// register writes first, hardware events after so sets win
		if (reg_wr)
		begin
			case (reg_addr)
				spc_pkg::MODE_ADDR: n.mode = reg_wdata;
				spc_pkg::STAT_ADDR:
				begin
					if (reg_wdata[spc_pkg::S_FAULT])
						n.fault = 1'b0;
					if (reg_wdata[spc_pkg::S_OVR])
						n.ovr = 1'b0;
				end
				spc_pkg::TXD_ADDR:
				begin
					if (!r.txf)
					begin
						n.txd = reg_wdata;
						n.txf = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (pop)
			n.rxf = 1'b0;
		case (reg_addr)
			spc_pkg::MODE_ADDR: n.rdata = r.mode;
			spc_pkg::STAT_ADDR: n.rdata = {11'h000, r.busy, r.rxf, r.txf, r.ovr, r.fault};
			spc_pkg::TXD_ADDR: n.rdata = r.txd;
			spc_pkg::RXD_ADDR: n.rdata = r.rxd;
			default: n.rdata = 16'h0000;
		endcase
		if (!reg_rd)
			n.rdata = 16'h0000;
		// prescaler and rate generator run only while a master character is active
		if (r.mode[spc_pkg::M_EN] && r.mode[spc_pkg::M_MST] && r.busy)
		begin
			if (r.pcnt >= pre_lim(r.mode[spc_pkg::M_PRE+:2]))
			begin
				n.pcnt = 6'h00;
				rt = 1'b1;
			end
			else
				n.pcnt = r.pcnt + 6'h01;
			if (rt)
			begin
				// half period is pm+2 rate ticks, never above a quarter clock rate
				if (r.bcnt >= {1'b0, r.mode[spc_pkg::M_PM+:4]} + 5'h01)
				begin
					n.bcnt = 5'h00;
					hedge = 1'b1;
				end
				else
					n.bcnt = r.bcnt + 5'h01;
			end
		end
		else
		begin
			n.pcnt = 6'h00;
			n.bcnt = 5'h00;
		end
		n.sprev = sclk_q;
		if (r.mode[spc_pkg::M_MST])
		begin
			lead = hedge && !r.ph;
			trail = hedge && r.ph;
		end
		else if (r.mode[spc_pkg::M_EN] && sel_act && r.busy && (sclk_q != r.sprev))
		begin
			lead = (sclk_q != r.mode[spc_pkg::M_CI]);
			trail = (sclk_q == r.mode[spc_pkg::M_CI]);
		end
		din = r.mode[spc_pkg::M_LOOP] ? r.dout : (r.mode[spc_pkg::M_MST] ? miso_q : mosi_q);
		if (lead)
		begin
			n.ph = 1'b1;
			if (r.mode[spc_pkg::M_CP])
			begin
				n.dout = r.tsh[15];
				n.tsh = {r.tsh[14:0], 1'b1};
			end
			else
			begin
				n.rsh = {r.rsh[14:0], din};
				n.cnt = r.cnt + 5'h01;
			end
		end
		if (trail)
		begin
			n.ph = 1'b0;
			if (r.mode[spc_pkg::M_CP])
			begin
				n.rsh = {r.rsh[14:0], din};
				n.cnt = r.cnt + 5'h01;
			end
			done = (n.cnt == len);
			if (done)
			begin
				n.busy = 1'b0;
				if (r.rxf && !pop)
					n.ovr = 1'b1;
				else
				begin
					n.rxd = n.rsh;
					n.rxf = 1'b1;
				end
			end
			else if (!r.mode[spc_pkg::M_CP])
			begin
				n.dout = r.tsh[15];
				n.tsh = {r.tsh[14:0], 1'b1};
			end
		end
		// slave aborts the character when select goes high
		if (!r.mode[spc_pkg::M_MST] && !sel_act)
		begin
			n.busy = 1'b0;
			n.ph = 1'b0;
			n.cnt = 5'h00;
		end
		// load next character, in the same cycle the last one ends
		if (r.mode[spc_pkg::M_EN] && !n.busy && (r.mode[spc_pkg::M_MST] ? r.txf : sel_act))
		begin
			n.busy = 1'b1;
			n.cnt = 5'h00;
			n.ph = 1'b0;
			n.rsh = 16'h0000;
			n.bcnt = 5'h00;
			// slave with nothing queued sends ones
			n.tsh = r.txf ? (r.txd << (spc_pkg::CLEN_MAX - clen)) : 16'hffff;
			if (r.txf)
				n.txf = 1'b0;
			if (!r.mode[spc_pkg::M_CP])
			begin
				n.dout = n.tsh[15];
				n.tsh = {n.tsh[14:0], 1'b1};
			end
		end
		// a second master pulls our select low
		if (r.mode[spc_pkg::M_EN] && r.mode[spc_pkg::M_MST] && sel_act)
		begin
			n.fault = 1'b1;
			n.mode[spc_pkg::M_EN] = 1'b0;
		end
		if (!n.mode[spc_pkg::M_EN])
		begin
			n.busy = 1'b0;
			n.ph = 1'b0;
			n.cnt = 5'h00;
			n.pcnt = 6'h00;
			n.bcnt = 5'h00;
		end
		// pins, all registered
		n.sclk = n.mode[spc_pkg::M_CI] ^ (n.busy && n.ph);
		n.mosi = n.dout;
		n.miso = n.dout;
		n.sclk_oen = pin_oen(n.mode[spc_pkg::M_EN] && n.mode[spc_pkg::M_MST] && !n.fault,
			n.mode[spc_pkg::M_OD], n.sclk);
		n.mosi_oen = pin_oen(n.mode[spc_pkg::M_EN] && n.mode[spc_pkg::M_MST] && !n.fault,
			n.mode[spc_pkg::M_OD], n.mosi);
		n.miso_oen = pin_oen(n.mode[spc_pkg::M_EN] && !n.mode[spc_pkg::M_MST] && sel_act,
			n.mode[spc_pkg::M_OD], n.miso);
		n.seln = !(n.mode[spc_pkg::M_MST] && n.busy);
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			r <= '0;
			r.mode <= spc_pkg::MODE_RST;
			r.sprev <= 1'b1;
			r.sclk_oen <= 1'b1;
			r.mosi_oen <= 1'b1;
			r.miso_oen <= 1'b1;
			r.seln <= 1'b1;
		end
		else
			r <= n;
	end

	assign reg_rdata = r.rdata;
	assign serial_shift_clock_out = r.sclk;
	assign serial_shift_clock_oe_n = r.sclk_oen;
	assign controller_out_line_out = r.mosi;
	assign controller_out_line_oe_n = r.mosi_oen;
	assign controller_in_line_out = r.miso;
	assign controller_in_line_oe_n = r.miso_oen;
	assign select_output_n = r.seln;

	chk_fault_set: assert property (@(posedge clk) disable iff (sys_rst)
		(r.mode[spc_pkg::M_EN] && r.mode[spc_pkg::M_MST] && sel_act)
		|=> (r.fault && !r.mode[spc_pkg::M_EN] && !r.busy))
		else $error("select fault not taken");

	chk_fault_drivers: assert property (@(posedge clk) disable iff (sys_rst)
		r.fault |-> (serial_shift_clock_oe_n && controller_out_line_oe_n))
		else $error("drivers on during fault");

	chk_idle_clock: assert property (@(posedge clk) disable iff (sys_rst)
		(!r.busy && r.mode[spc_pkg::M_MST]) |-> (serial_shift_clock_out == r.mode[spc_pkg::M_CI]))
		else $error("master clock not idle");

	chk_miso_dir: assert property (@(posedge clk) disable iff (sys_rst)
		r.mode[spc_pkg::M_MST] |-> controller_in_line_oe_n)
		else $error("controller-in driven as master");

	chk_mosi_dir: assert property (@(posedge clk) disable iff (sys_rst)
		!r.mode[spc_pkg::M_MST] |-> controller_out_line_oe_n)
		else $error("controller-out driven as slave");

	chk_off_still: assert property (@(posedge clk) disable iff (sys_rst)
		!r.mode[spc_pkg::M_EN] |-> (!r.busy && (r.pcnt == 6'h00) && (r.bcnt == 5'h00)))
		else $error("disabled port still running");

	chk_slave_unsel: assert property (@(posedge clk) disable iff (sys_rst)
		(!r.mode[spc_pkg::M_MST] && !sel_act) |=> (!r.busy && (r.cnt == 5'h00)))
		else $error("slave shifting without select");

	chk_tx_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_wr && (reg_addr == spc_pkg::TXD_ADDR) && !r.txf) |=> (r.txf && (r.txd == $past(reg_wdata))))
		else $error("transmit hold not loaded");

	chk_read_lat: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && (reg_addr == spc_pkg::MODE_ADDR)) |=> (reg_rdata == $past(r.mode)) ##1 (reg_rdata == 16'h0000 || $past(reg_rd)))
		else $error("mode read data wrong");
endmodule : spc_core

/* File: core/spc_pkg.sv */
// shared constants of the serial peripheral core
package spc_pkg;
	localparam int AW = 4;
	localparam int DW = 16;
	localparam logic [3:0] MODE_ADDR = 4'h0;
	localparam logic [3:0] STAT_ADDR = 4'h1;
	localparam logic [3:0] TXD_ADDR = 4'h2;
	localparam logic [3:0] RXD_ADDR = 4'h3;
	localparam int M_EN = 0;
	localparam int M_MST = 1;
	localparam int M_LOOP = 2;
	localparam int M_CI = 3;
	localparam int M_CP = 4;
	localparam int M_OD = 5;
	localparam int M_CLEN = 6;
	localparam int M_PRE = 10;
	localparam int M_PM = 12;
	localparam int S_FAULT = 0;
	localparam int S_OVR = 1;
	localparam int S_TXF = 2;
	localparam int S_RXF = 3;
	localparam int S_BUSY = 4;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [3:0] CLEN_MIN = 4'h3;
	localparam logic [3:0] CLEN_MAX = 4'hf;
	localparam logic [5:0] PRE_LIM1 = 6'h00;
	localparam logic [5:0] PRE_LIM4 = 6'h03;
	localparam logic [5:0] PRE_LIM16 = 6'h0f;
	localparam logic [5:0] PRE_LIM64 = 6'h3f;
	localparam int CLK_MHZ = 100;
	localparam int MST_HALF_MIN = 2;
endpackage : spc_pkg

/* File: core/spc_sync3.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module spc_sync3 #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} spc_sync_st_t;

	spc_sync_st_t st_reg;
	spc_sync_st_t st_next;

	always_comb
	begin
		st_next = st_reg;
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		// a bit moves only once stages two and three agree
		st_next.q = (st_reg.s2 & ~(st_reg.s2 ^ st_reg.s3)) | (st_reg.q & (st_reg.s2 ^ st_reg.s3));
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_reg <= '1;
		else
			st_reg <= st_next;
	end

	assign q = st_reg.q;
endmodule : spc_sync3

/* File: tb/spc_far_end.sv */
// behavioural far-side peripheral, clock idle low, sample on leading edge
`timescale 1ns/1ps
module spc_far_end (
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic mosi,
	output logic miso,
	input wire logic [4:0] len,
	input wire logic [15:0] reply,
	output logic [15:0] got
);
	logic [15:0] sh;
	int n;
	initial
	begin
		miso = 1'b0;
		got = '0;
		sh = '0;
		n = 0;
	end
	always @(negedge sel_n)
	begin
		sh = reply;
		n = 0;
		miso = reply[len-1];
	end
	always @(posedge sclk)
		if (!sel_n)
		begin
			got = {got[14:0], mosi};
			n = n + 1;
		end
	always @(negedge sclk)
		if (!sel_n)
		begin
			if (n == len)
			begin
				n = 0;
				sh = reply;
			end
			else
				sh = sh << 1;
			miso = sh[len-1];
		end
	// released line shows the inverse of its last level
	always @(posedge sel_n)
		miso = ~miso;
endmodule : spc_far_end

/* File: tb/test_serial_peripheral_core.sv */
// self-checking bench of the serial peripheral core
`timescale 1ns/1ps
module test_serial_peripheral_core;
	logic clk, sys_rst, wr, rd, sel_n;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, rv, reply, got;
	logic sck_o, sck_oe_n, co_o, co_oe_n, ci_o, ci_oe_n, sel_o_n, miso;
	logic [4:0] plen;
	int num_errors, samples_checked, seed, i, k;
	int lens[3] = '{4, 8, 16};
	logic [15:0] exp_q[$];
	wire sck = sck_oe_n ? 1'b0 : sck_o;
	wire co = co_oe_n ? 1'b1 : co_o;
	wire ci = ci_oe_n ? miso : ci_o;
	spc_core i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdata), .serial_shift_clock_in(sck), .serial_shift_clock_out(sck_o),
		.serial_shift_clock_oe_n(sck_oe_n), .controller_out_line_in(co), .controller_out_line_out(co_o),
		.controller_out_line_oe_n(co_oe_n), .controller_in_line_in(ci), .controller_in_line_out(ci_o),
		.controller_in_line_oe_n(ci_oe_n), .select_input_n(sel_n), .select_output_n(sel_o_n));
	spc_far_end i_far (.sclk(sck), .sel_n(sel_o_n), .mosi(co), .miso(miso), .len(plen), .reply(reply), .got(got));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task final_report;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	task chk(input logic [15:0] g, input logic [15:0] e, input string what);
		samples_checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask : chk
	task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 rv = rdata;
	endtask : bus
	function automatic logic [15:0] mode(int lp, int len, int pre, int pm, int cinv);
		return 16'(3 | (lp << 2) | (cinv << 3) | ((len - 1) << 6) | (pre << 10) | (pm << 12));
	endfunction : mode
	task wait_rx;
		for (k = 0; k < 4000; k++)
		begin
			bus(1'b0, spc_pkg::STAT_ADDR, 16'h0000);
			if (rv[spc_pkg::S_RXF] === 1'b1)
				break;
		end
		if (k == 4000)
		begin
			num_errors++;
			$display("[ERR] %0t receive timeout", $time);
			final_report();
		end
	endtask : wait_rx
	task pop_rx(input logic [15:0] m);
		wait_rx();
		bus(1'b0, spc_pkg::RXD_ADDR, 16'h0000);
		chk(rv, exp_q.pop_front() & m, "rx char");
	endtask : pop_rx
	task xfer(input int lp, input int len);
		logic [15:0] m, d;
		m = 16'((32'h1 << len) - 1);
		d = 16'($random(seed));
		reply = 16'($random(seed));
		plen = 5'(len);
		// pin path adds four cycles, so external master reads need a half period of six
		bus(1'b1, spc_pkg::MODE_ADDR, mode(lp, len, 0, lp ? 0 : 4, 0));
		bus(1'b1, spc_pkg::TXD_ADDR, d);
		exp_q.push_back(lp ? d : reply);
		pop_rx(m);
		if (!lp)
			chk(got & m, d & m, "far side char");
	endtask : xfer
	initial
	begin
		seed = 93196;
		num_errors = 0;
		samples_checked = 0;
		{wr, rd, addr, wdata, reply} = '0;
		plen = 5'h08;
		sel_n = 1'b1;
		sys_rst = 1'b1;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		bus(1'b0, spc_pkg::MODE_ADDR, 16'h0000);
		chk(rv, spc_pkg::MODE_RST, "mode reset");
		bus(1'b0, spc_pkg::STAT_ADDR, 16'h0000);
		chk(rv, 16'h0000, "status reset");
		bus(1'b1, 4'h9, 16'hffff);
		bus(1'b0, 4'h9, 16'h0000);
		chk(rv, 16'h0000, "unmapped read");
		chk({sck_oe_n, co_oe_n, ci_oe_n, sel_o_n}, 16'h000f, "idle drivers");
		$display("test reset done");
		foreach (lens[j])
			xfer(0, lens[j]);
		xfer(1, 5);
		$display("test single chars done");
		reply = 16'($random(seed));
		plen = 5'h08;
		bus(1'b1, spc_pkg::MODE_ADDR, mode(0, 8, 0, 4, 0));
		bus(1'b1, spc_pkg::TXD_ADDR, 16'h00a5);
		repeat (3) @(posedge clk);
		bus(1'b1, spc_pkg::TXD_ADDR, 16'h003c);
		exp_q.push_back(reply);
		exp_q.push_back(reply);
		pop_rx(16'h00ff);
		pop_rx(16'h00ff);
		chk(got & 16'h00ff, 16'h003c, "second far char");
		bus(1'b0, spc_pkg::STAT_ADDR, 16'h0000);
		chk(rv & 16'h0002, 16'h0000, "no overrun");
		$display("test back to back done");
		for (i = 0; i < 4; i++)
		begin
			bus(1'b1, spc_pkg::MODE_ADDR, mode(1, 4, i, 1, i % 2));
			repeat (2) @(posedge clk);
			chk(16'(sck_o), 16'(i % 2), "idle clock level");
			bus(1'b1, spc_pkg::TXD_ADDR, 16'h0009);
			exp_q.push_back(16'h0009);
			rv = 16'(sck_o);
			for (k = 0; k < 1000 && sck_o === rv[0]; k++)
				@(posedge clk) #1;
			for (k = 0; k < 1000 && sck_o !== rv[0]; k++)
				@(posedge clk) #1;
			chk(16'(k), 16'(3 * (32'h1 << (2 * i))), "first half period");
			pop_rx(16'h000f);
		end
		$display("test rate done");
		bus(1'b1, spc_pkg::MODE_ADDR, mode(0, 8, 0, 0, 0));
		sel_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk({sck_oe_n, co_oe_n}, 16'h0003, "drivers off");
		bus(1'b0, spc_pkg::STAT_ADDR, 16'h0000);
		chk(rv & 16'h0001, 16'h0001, "fault flag");
		bus(1'b0, spc_pkg::MODE_ADDR, 16'h0000);
		chk(rv & 16'h0001, 16'h0000, "port disabled");
		sel_n <= 1'b1;
		bus(1'b1, spc_pkg::STAT_ADDR, 16'h0001);
		bus(1'b0, spc_pkg::STAT_ADDR, 16'h0000);
		chk(rv & 16'h0001, 16'h0000, "fault cleared");
		$display("test fault done");
		final_report();
	end
endmodule : test_serial_peripheral_core
